// *** include/eqr_pkg.sv ***
// shared constants for the equalizer control and status register bank
package eqr_pkg;

   // register port widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   // equalizers with control registers, and those with coefficient blocks
   localparam int NUM_EQ = 3;
   localparam int NUM_COEF_EQ = 2;
   localparam int NUM_BANDS = 5;

   // register indices as printed
   localparam logic [11:0] STATUS_OFS = 12'he01;
   localparam logic [11:0] GAIN_A_OFS [NUM_EQ] = '{12'he10, 12'he26, 12'he3c};
   localparam logic [11:0] GAIN_B_OFS [NUM_EQ] = '{12'he11, 12'he27, 12'he3d};
   localparam logic [11:0] COEF_OFS [NUM_COEF_EQ] = '{12'he12, 12'he28};

   // coefficient words per equalizer (first to last index inclusive)
   localparam int COEF_WORDS = 19;

   // field positions in the two control registers
   localparam int ENA_BIT = 0;
   localparam int MODE_BIT = 0;
   localparam int B1_LSB = 11;
   localparam int B2_LSB = 6;
   localparam int B3_LSB = 1;
   localparam int B4_LSB = 11;
   localparam int B5_LSB = 6;
   localparam int GAIN_W = 5;

   // gain codes
   localparam logic [4:0] GAIN_RST = 5'h0c;
   localparam logic [4:0] GAIN_MAX = 5'h18;
   localparam logic [5:0] GAIN_OFFSET_DB = 6'h0c;

   // reset values and writable bits of the control registers
   localparam logic [15:0] CTL_A_RST = {GAIN_RST, GAIN_RST, GAIN_RST, 1'b0};
   localparam logic [15:0] CTL_B_RST = {GAIN_RST, GAIN_RST, 6'h00};
   localparam logic [15:0] CTL_A_MASK = 16'hffff;
   localparam logic [15:0] CTL_B_MASK = 16'hffc1;

   // layout of the status register
   localparam int STS_LSB = 4;
   localparam int STS_W = 12;
   localparam int STS_EQ_LSB = 8;
   localparam int STS_DYN_LSB = 4;
   localparam int STS_FILT_LSB = 0;

endpackage

// *** verilog/eqr_gain_dec.sv ***
`timescale 1ns/1ps
`default_nettype none
// turns a band gain code into signed decibels
module eqr_gain_dec
   import eqr_pkg::*;
(
   input wire logic [4:0] i_code, // band gain code
   output logic signed [5:0] o_db, // gain in dB, -12 to +12
   output logic o_reserved // code above the top step
);

   // reserved codes clamp to the top step so the filter never sees a wild gain
   always_comb begin
      o_reserved = (i_code > GAIN_MAX); // see RULE_09
      if (o_reserved) begin
         o_db = $signed({1'b0, GAIN_MAX} - GAIN_OFFSET_DB);
      end else begin
         o_db = $signed({1'b0, i_code} - GAIN_OFFSET_DB); // see RULE_05
      end
   end

endmodule
`default_nettype wire

// *** verilog/eqr_eq_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
// the two control registers and the run state of one equalizer
module eqr_eq_ctl
   import eqr_pkg::*;
(
   input wire logic i_clk, // core clock
   input wire logic i_rst_n, // synchronised reset, active low
   input wire logic i_wr_a, // write to first control register
   input wire logic i_wr_b, // write to second control register
   input wire logic [15:0] i_wdata, // write data
   input wire logic i_cycles_short, // too few core cycles for a new path
   output logic [15:0] o_ctl_a, // first control register
   output logic [15:0] o_ctl_b, // second control register
   output logic o_active // equalizer really running
);

   // gains, enable request; all 16 bits writable, none held at zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ctl_a <= CTL_A_RST; // see RULE_03
      end else if (i_wr_a) begin
         o_ctl_a <= i_wdata & CTL_A_MASK; // see RULE_06
      end
   end

   // band 4/5 gains and band 1 type
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ctl_b <= CTL_B_RST; // see RULE_04
      end else if (i_wr_b) begin
         o_ctl_b <= i_wdata & CTL_B_MASK; // see RULE_07
      end
   end

   // a start only succeeds with enough core cycles; a running path stays put
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_active <= 1'b0;
      end else if (i_wr_a) begin
         if (!i_wdata[ENA_BIT]) begin
            o_active <= 1'b0;
         end else if (!o_active && !i_cycles_short) begin
            o_active <= 1'b1; // see RULE_10
         end
      end
   end

endmodule
`default_nettype wire

// *** verilog/eqr_regs.sv ***
// How it works
// RULE_01: status bits 15:4 show read-only enables
// RULE_02: status order: equalizers, dynamics, then filters
// RULE_03: first control bit 0 enables, resets 0
// RULE_04: second control bit 0: shelving 0, peak 1
// RULE_05: gain codes span -12 to +12 dB
// RULE_06: band 1..3 gains at 15:11, 10:6, 5:1
// RULE_07: band 4..5 gains; all gains reset 0x0c
// RULE_08: 16-bit coefficient words stored as written
// RULE_09: code 0 is -12 dB; above 11000 reserved
// RULE_10: start refused when core cycles too few
// RULE_11: unused bits read zero, writes ignored
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module eqr_regs
   import eqr_pkg::*;
#(
   parameter int NCOEF = COEF_WORDS // coefficient words per equalizer
) (
   input wire logic i_clk, // core clock, 40 MHz
   input wire logic i_resetn, // asynchronous reset, active low
   input wire logic [11:0] i_addr, // register index
   input wire logic [15:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   input wire logic i_cycles_short, // core clock too slow for a new path
   input wire logic i_eq4_active, // fourth equalizer running
   input wire logic [3:0] i_dyn_active, // dynamics {2R,2L,1R,1L}
   input wire logic [3:0] i_filt_active, // filters 4 down to 1
   output logic [15:0] o_rdata, // read data, cycle after strobe
   output logic [2:0] o_eq_enable, // equalizers 3..1 running
   output logic [2:0] o_band1_peak, // band 1 peak type per equalizer
   output logic [74:0] o_band_code, // 15 gain codes, eq1 band1 lowest
   output logic [89:0] o_band_db, // 15 signed dB values, 6 bits each
   output logic [14:0] o_band_reserved, // gain code is reserved
   output logic [NUM_COEF_EQ*NCOEF*16-1:0] o_coef // coefficient words
);

   ////////////////////////////////////////////////////////////////////////
   // reset release

   logic [1:0] rst_sync_r;
   logic rst_n;

   // async assert, release through two flops
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // address decode

   logic [NUM_EQ-1:0] wr_a;
   logic [NUM_EQ-1:0] wr_b;
   logic [NUM_EQ-1:0] hit_a;
   logic [NUM_EQ-1:0] hit_b;
   logic [NUM_COEF_EQ-1:0] hit_coef;
   logic [4:0] coef_idx [NUM_COEF_EQ];
   logic hit_status;

   // status register is read only; writes fall on nothing
   assign hit_status = (i_addr == STATUS_OFS); // see RULE_01

   genvar e;
   generate
      for (e = 0; e < NUM_EQ; e++) begin : g_dec
         assign hit_a[e] = (i_addr == GAIN_A_OFS[e]);
         assign hit_b[e] = (i_addr == GAIN_B_OFS[e]);
         assign wr_a[e] = i_wr && hit_a[e];
         assign wr_b[e] = i_wr && hit_b[e];
      end
      for (e = 0; e < NUM_COEF_EQ; e++) begin : g_cdec
         logic [11:0] rel;
         // unsigned wrap makes indices below the base land out of range
         assign rel = i_addr - COEF_OFS[e];
         assign hit_coef[e] = (rel < 12'(NCOEF));
         assign coef_idx[e] = rel[4:0];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // equalizer control registers

   logic [15:0] ctl_a [NUM_EQ];
   logic [15:0] ctl_b [NUM_EQ];

   generate
      for (e = 0; e < NUM_EQ; e++) begin : g_eq
         eqr_eq_ctl u_ctl (
            .i_clk(i_clk),
            .i_rst_n(rst_n),
            .i_wr_a(wr_a[e]),
            .i_wr_b(wr_b[e]),
            .i_wdata(i_wdata),
            .i_cycles_short(i_cycles_short),
            .o_ctl_a(ctl_a[e]),
            .o_ctl_b(ctl_b[e]),
            .o_active(o_eq_enable[e])
         );
         // band 1 type straight from its flop
         assign o_band1_peak[e] = ctl_b[e][MODE_BIT]; // see RULE_04
         // raw gain codes, five per equalizer
         assign o_band_code[e*25 +: 5] = ctl_a[e][B1_LSB +: GAIN_W]; // see RULE_06
         assign o_band_code[e*25+5 +: 5] = ctl_a[e][B2_LSB +: GAIN_W];
         assign o_band_code[e*25+10 +: 5] = ctl_a[e][B3_LSB +: GAIN_W];
         assign o_band_code[e*25+15 +: 5] = ctl_b[e][B4_LSB +: GAIN_W]; // see RULE_07
         assign o_band_code[e*25+20 +: 5] = ctl_b[e][B5_LSB +: GAIN_W];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // gain decode, registered so the filters see clean levels

   genvar b;
   generate
      for (b = 0; b < NUM_EQ*NUM_BANDS; b++) begin : g_band
         logic signed [5:0] db;
         logic rsv;

         eqr_gain_dec u_dec (
            .i_code(o_band_code[b*5 +: 5]),
            .o_db(db),
            .o_reserved(rsv)
         );

         // one cycle behind the code register
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               o_band_db[b*6 +: 6] <= 6'h00; // reset code 0x0c is 0 dB
               o_band_reserved[b] <= 1'b0;
            end else begin
               o_band_db[b*6 +: 6] <= db; // see RULE_05
               o_band_reserved[b] <= rsv; // see RULE_09
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // coefficient storage

   logic [15:0] coef_r [NUM_COEF_EQ][NCOEF];

   // whole words, no masking: software computes them
   generate
      for (e = 0; e < NUM_COEF_EQ; e++) begin : g_coef
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               for (int k = 0; k < NCOEF; k++) begin
                  coef_r[e][k] <= 16'h0000;
               end
            end else if (i_wr && hit_coef[e]) begin
               coef_r[e][coef_idx[e]] <= i_wdata; // see RULE_08
            end
         end
         for (b = 0; b < NCOEF; b++) begin : g_out
            assign o_coef[(e*NCOEF+b)*16 +: 16] = coef_r[e][b];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // status word

   logic [STS_W-1:0] sts_field;

   // equalizer 4, dynamics and filters are reported by their own blocks
   always_comb begin
      sts_field = '0;
      sts_field[STS_EQ_LSB +: 3] = o_eq_enable; // see RULE_02
      sts_field[STS_EQ_LSB+3] = i_eq4_active;
      sts_field[STS_DYN_LSB +: 4] = i_dyn_active;
      sts_field[STS_FILT_LSB +: 4] = i_filt_active;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux

   logic [15:0] rd_mux;

   // unmapped indices and unused bits answer zero
   always_comb begin
      rd_mux = 16'h0000;
      if (hit_status) begin
         rd_mux = {sts_field, 4'h0}; // see RULE_11
      end
      for (int i = 0; i < NUM_EQ; i++) begin
         if (hit_a[i]) begin
            rd_mux = ctl_a[i];
         end
         if (hit_b[i]) begin
            rd_mux = ctl_b[i] & CTL_B_MASK; // see RULE_11
         end
      end
      for (int i = 0; i < NUM_COEF_EQ; i++) begin
         if (hit_coef[i]) begin
            rd_mux = coef_r[i][coef_idx[i]];
         end
      end
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// *** tb/eqr_regs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module eqr_regs_chk
   import eqr_pkg::*;
#(
   parameter int NCOEF = COEF_WORDS // coef words
) (
   input wire logic i_clk, // clock
   input wire logic i_resetn, // reset
   input wire logic [11:0] i_addr, // index
   input wire logic [15:0] i_wdata, // data
   input wire logic i_wr, // write
   input wire logic i_rd, // read
   input wire logic i_cycles_short, // slow clock
   input wire logic i_eq4_active, // eq4
   input wire logic [3:0] i_dyn_active, // dynamics
   input wire logic [3:0] i_filt_active, // filters
   input wire logic [15:0] o_rdata, // read data
   input wire logic [2:0] o_eq_enable, // running
   input wire logic [2:0] o_band1_peak, // peak
   input wire logic [74:0] o_band_code, // codes
   input wire logic [89:0] o_band_db, // dB
   input wire logic [14:0] o_band_reserved, // reserved
   input wire logic [NUM_COEF_EQ*NCOEF*16-1:0] o_coef // coefs
);
   logic rd_b_r;
   logic a0;
   logic b0;
   // eq1 control writes, watched as the sample case
   assign a0 = i_wr && i_addr == GAIN_A_OFS[0];
   assign b0 = i_wr && i_addr == GAIN_B_OFS[0];
   // second control reads, answered one cycle on
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_b_r <= 1'b0;
      end else begin
         rd_b_r <= i_rd && i_addr inside {GAIN_B_OFS[0], GAIN_B_OFS[1], GAIN_B_OFS[2]};
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence sts_rd_s;
      i_rd && i_addr == STATUS_OFS;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   status_read_a: assert property (sts_rd_s |=> o_rdata == {$past(i_eq4_active),
      $past(o_eq_enable), $past(i_dyn_active), $past(i_filt_active), 4'h0})
      else $error("status read wrong");
   ctl_b_zero_a: assert property (rd_b_r |-> o_rdata[5:1] == 5'h00)
      else $error("unused bits not zero");
   en_start_a: assert property (a0 && i_wdata[0] && !i_cycles_short |=> o_eq_enable[0])
      else $error("enable did not start");
   en_refuse_a: assert property (a0 && i_cycles_short && i_wdata[0] |=> $stable(o_eq_enable[0]))
      else $error("start not refused");
   en_stop_a: assert property (a0 && !i_wdata[0] |=> !o_eq_enable[0])
      else $error("enable did not stop");
   en_hold_a: assert property (!a0 |=> $stable(o_eq_enable[0]))
      else $error("enable changed without write");
   peak_sel_a: assert property (b0 |=> o_band1_peak[0] == $past(i_wdata[0]))
      else $error("band1 type wrong");
   gain_field_a: assert property (a0 |=> o_band_code[14:0] ==
      {$past(i_wdata[5:1]), $past(i_wdata[10:6]), $past(i_wdata[15:11])})
      else $error("gain fields wrong");
   gain_db_a: assert property (a0 |-> ##2 o_band_db[5:0] ==
      (($past(i_wdata[15:11], 2) > GAIN_MAX) ? 6'h0c : {1'b0, $past(i_wdata[15:11], 2)} - 6'h0c))
      else $error("gain dB wrong");
   coef_store_a: assert property (i_wr && i_addr == COEF_OFS[0] |=>
      o_coef[15:0] == $past(i_wdata)) else $error("coef not stored");
endmodule
bind eqr_regs eqr_regs_chk #(.NCOEF(NCOEF)) eqr_regs_chk_i (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cycles_short(i_cycles_short),
   .i_eq4_active(i_eq4_active), .i_dyn_active(i_dyn_active), .i_filt_active(i_filt_active),
   .o_rdata(o_rdata), .o_eq_enable(o_eq_enable), .o_band1_peak(o_band1_peak),
   .o_band_code(o_band_code), .o_band_db(o_band_db), .o_band_reserved(o_band_reserved),
   .o_coef(o_coef));
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import eqr_pkg::*;
   localparam int NC = 19;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [11:0] i_addr = 12'h000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_cycles_short = 1'b0;
   logic i_eq4_active = 1'b0;
   logic [3:0] i_dyn_active = 4'h0;
   logic [3:0] i_filt_active = 4'h0;
   logic [15:0] o_rdata;
   logic [2:0] o_eq_enable;
   logic [2:0] o_band1_peak;
   logic [74:0] o_band_code;
   logic [89:0] o_band_db;
   logic [14:0] o_band_reserved;
   logic [NUM_COEF_EQ*NC*16-1:0] o_coef;
   logic [2:0] en;
   logic [15:0] w;
   int seed = 32'h89f1;
   int bad_count = 0;
   int compares = 0;
   always #12.5 i_clk = ~i_clk;
   eqr_regs #(.NCOEF(NC)) eqr_regs_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cycles_short(i_cycles_short),
      .i_eq4_active(i_eq4_active), .i_dyn_active(i_dyn_active), .i_filt_active(i_filt_active),
      .o_rdata(o_rdata), .o_eq_enable(o_eq_enable), .o_band1_peak(o_band1_peak),
      .o_band_code(o_band_code), .o_band_db(o_band_db), .o_band_reserved(o_band_reserved),
      .o_coef(o_coef));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // legal gain code only; reserved codes are swept separately
   function automatic logic [4:0] g();
      return 5'($unsigned($random(seed)) % 25);
   endfunction
   function automatic logic [5:0] db_of(input logic [4:0] c);
      return (c > 5'h18) ? 6'h0c : {1'b0, c} - 6'h0c;
   endfunction
   // each write also moves the status inputs, so reads see fresh values
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      i_eq4_active <= 1'($random(seed));
      i_dyn_active <= 4'($random(seed));
      i_filt_active <= 4'($random(seed));
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic st();
      rd(STATUS_OFS, {i_eq4_active, en, i_dyn_active, i_filt_active, 4'h0});
   endtask
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      en = 3'h0;
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clk);
      for (int e = 0; e < NUM_EQ; e++) begin
         rd(GAIN_A_OFS[e], 16'h6318);
         rd(GAIN_B_OFS[e], 16'h6300);
      end
      st();
      // eq2 is started while cycles are short and must stay off
      for (int e = 0; e < NUM_EQ; e++) begin
         i_cycles_short <= e[0];
         w = {g(), g(), g(), 1'b1};
         wr(GAIN_A_OFS[e], w);
         en[e] = ~e[0];
         rd(GAIN_A_OFS[e], w);
         chk(16'(o_eq_enable), 16'(en));
      end
      st();
      // stop works even when short; a refused start needs a fresh write
      i_cycles_short <= 1'b1;
      wr(GAIN_A_OFS[0], 16'h6318);
      // eq1 start while short is refused, running eq3 is left alone
      wr(GAIN_A_OFS[0], 16'h6319);
      wr(GAIN_A_OFS[2], 16'h6319);
      i_cycles_short <= 1'b0;
      wr(GAIN_A_OFS[1], 16'h6319);
      en = 3'b110;
      st();
      wr(GAIN_B_OFS[2], 16'hffff);
      rd(GAIN_B_OFS[2], 16'hffc1);
      chk(16'(o_band1_peak), 16'h0004);
      chk(16'(o_band_code[74:65]), 16'h03ff);
      // whole code range, reserved codes included
      for (int c = 0; c < 32; c++) begin
         wr(GAIN_A_OFS[0], {5'(c), 11'h318});
         @(posedge i_clk);
         #1;
         chk({10'h000, o_band_db[5:0]}, {10'h000, db_of(5'(c))});
         chk(16'(o_band_reserved[0]), 16'(c > 24));
      end
      for (int k = 0; k < 2 * NC; k++) begin
         w = 16'($random(seed));
         wr(COEF_OFS[k / NC] + 12'(k % NC), w);
         rd(COEF_OFS[k / NC] + 12'(k % NC), w);
         chk(o_coef[k*16 +: 16], w);
      end
      wr(STATUS_OFS, 16'hffff);
      rd(12'he25, 16'h0000);
      st();
      stop_test();
   end
endmodule
`default_nettype wire
